// ==== include/hbc_pkg.sv ====
// shared types, register map and arithmetic for the interpolation mode control block
`default_nettype none
package hbc_pkg;

    localparam int HBC_W = 16;

    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } hbc_sample_t;

    typedef struct packed {
        logic [1:0] firstHalfbandMode;
        logic       firstStageBypass;
        logic [5:0] secondHalfbandMode;
        logic       secondStageBypass;
        logic [5:0] thirdHalfbandMode;
        logic       thirdStageBypass;
        logic       lowSideband;
        logic       inphaseCopyToQuad;
    } hbc_cfg_t;

    typedef enum logic {
        HBC_IDLE   = 1'b0,
        HBC_WAIT_B = 1'b1
    } hbc_phase_t;

    // register map
    localparam logic [7:0] HBC_ADDR_DP = 8'h1b;
    localparam logic [7:0] HBC_ADDR_S1 = 8'h1c;
    localparam logic [7:0] HBC_ADDR_S2 = 8'h1d;
    localparam logic [7:0] HBC_ADDR_S3 = 8'h1e;

    // field positions
    localparam int HBC_BYPASS_BIT   = 0;
    localparam int HBC_MODE_LSB     = 1;
    localparam int HBC_S1_MODE_MSB  = 2;
    localparam int HBC_S6_MODE_MSB  = 6;
    localparam int HBC_SIDEBAND_BIT = 1;
    localparam int HBC_COPY_BIT     = 0;

    // values after reset
    localparam hbc_cfg_t   HBC_CFG_RST = '0;
    localparam logic [7:0] HBC_RD_RST  = 8'h00;

    // gap in cycles between the two outputs of one input, per stage
    localparam int HBC_GAP_S1 = 4;
    localparam int HBC_GAP_S2 = 2;
    localparam int HBC_GAP_S3 = 1;

    // half-band kernel -1 0 9 16 9 0 -1, scaled by 1/16
    localparam int HBC_TAP_NEAR  = 9;
    localparam int HBC_TAP_SHIFT = 4;
    localparam int HBC_ROT_SHIFT = 14;

    // carrier in steps of pi/4 per output sample, q14
    localparam logic signed [15:0] HBC_COS [8] = '{16'sh4000, 16'sh2d41, 16'sh0000, 16'shd2bf,
                                                   16'shc000, 16'shd2bf, 16'sh0000, 16'sh2d41};
    localparam logic signed [15:0] HBC_SIN [8] = '{16'sh0000, 16'sh2d41, 16'sh4000, 16'sh2d41,
                                                   16'sh0000, 16'shd2bf, 16'shc000, 16'shd2bf};

    function automatic logic signed [15:0] hbc_sat(input logic signed [32:0] v);
        if (v > 33'sd32767)
            return 16'sh7fff;
        else if (v < -33'sd32768)
            return 16'sh8000;
        else
            return v[15:0];
    endfunction

    function automatic logic signed [15:0] hbc_neg(input logic signed [15:0] v);
        return hbc_sat(-33'(v));
    endfunction

    // interpolated sample between the two near taps
    function automatic logic signed [15:0] hbc_odd(input logic signed [15:0] farA,
                                                   input logic signed [15:0] nearA,
                                                   input logic signed [15:0] nearB,
                                                   input logic signed [15:0] farB);
        logic signed [20:0] acc;
        acc = 21'(HBC_TAP_NEAR) * (21'(nearA) + 21'(nearB)) - (21'(farA) + 21'(farB));
        return hbc_sat(33'(acc >>> HBC_TAP_SHIFT));
    endfunction

    function automatic hbc_sample_t hbc_rot(input hbc_sample_t s, input logic [2:0] ph);
        logic signed [32:0] ri;
        logic signed [32:0] rq;
        hbc_sample_t        r;
        ri  = 33'(s.i * HBC_COS[ph]) - 33'(s.q * HBC_SIN[ph]);
        rq  = 33'(s.i * HBC_SIN[ph]) + 33'(s.q * HBC_COS[ph]);
        r.i = hbc_sat(ri >>> HBC_ROT_SHIFT);
        r.q = hbc_sat(rq >>> HBC_ROT_SHIFT);
        return r;
    endfunction

    // first stage shifts in half-rate steps, i.e. two eighths per code
    function automatic logic [2:0] hbc_step1(input logic [1:0] code);
        return {code, 1'b0};
    endfunction

    // six-bit codes: upper half decides, so odd codes fall onto a listed mode
    function automatic logic [2:0] hbc_step6(input logic [5:0] code);
        return code[5:3];
    endfunction

endpackage
`default_nettype wire

// ==== hw/hbc_halfband_stage.sv ====
// one 2x half-band interpolation stage with passband rotation and bypass
`timescale 1ns/10ps
`default_nettype none
module hbc_halfband_stage #(
    parameter int GAP = 1
) (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 bypass,
    input  wire logic [2:0]           step,
    input  wire logic                 qRun,
    input  wire logic                 inValid,
    input  wire hbc_pkg::hbc_sample_t inSample,
    output logic                      outValid,
    output hbc_pkg::hbc_sample_t      outSample
);
    // three taps suffice: the newest input is the fourth point of the kernel
    hbc_pkg::hbc_sample_t tap_q [3];
    hbc_pkg::hbc_sample_t tap_d [3];
    hbc_pkg::hbc_sample_t odd_q;
    hbc_pkg::hbc_sample_t odd_d;
    hbc_pkg::hbc_sample_t out_q;
    hbc_pkg::hbc_sample_t out_d;
    hbc_pkg::hbc_phase_t  st_q;
    hbc_pkg::hbc_phase_t  st_d;
    logic [2:0]           cnt_q;
    logic [2:0]           cnt_d;
    logic [2:0]           ph_q;
    logic [2:0]           ph_d;
    logic                 vld_q;
    logic                 vld_d;
    hbc_pkg::hbc_sample_t evenS;
    hbc_pkg::hbc_sample_t oddS;

    always_comb begin
        tap_d = tap_q;
        odd_d = odd_q;
        out_d = out_q;
        st_d  = st_q;
        cnt_d = cnt_q;
        ph_d  = ph_q;
        vld_d = 1'b0;
        evenS = tap_q[1];
        oddS  = odd_q;
        // stale frozen q must not leak into i through the rotation
        if (!qRun) begin
            evenS.q = '0;
            oddS.q  = '0;
        end
        if (bypass) begin
            // mode and phase have no effect here
            st_d = hbc_pkg::HBC_IDLE;
            if (inValid) begin
                out_d = inSample;
                vld_d = 1'b1;
            end
        end else begin
            unique case (st_q)
                hbc_pkg::HBC_IDLE: begin
                    if (inValid) begin
                        tap_d[0] = inSample;
                        for (int k = 1; k < 3; k++) begin
                            tap_d[k] = tap_q[k-1];
                        end
                        odd_d.i = hbc_pkg::hbc_odd(inSample.i, tap_q[0].i, tap_q[1].i, tap_q[2].i);
                        odd_d.q = hbc_pkg::hbc_odd(inSample.q, tap_q[0].q, tap_q[1].q, tap_q[2].q);
                        out_d   = hbc_pkg::hbc_rot(evenS, ph_q);
                        vld_d   = 1'b1;
                        ph_d    = ph_q + step;
                        cnt_d   = 3'(GAP - 1);
                        st_d    = hbc_pkg::HBC_WAIT_B;
                    end
                end
                hbc_pkg::HBC_WAIT_B: begin
                    // inputs arriving here are dropped; upstream spacing prevents it
                    if (cnt_q == 3'h0) begin
                        out_d = hbc_pkg::hbc_rot(oddS, ph_q);
                        vld_d = 1'b1;
                        ph_d  = ph_q + step;
                        st_d  = hbc_pkg::HBC_IDLE;
                    end else begin
                        cnt_d = cnt_q - 3'h1;
                    end
                end
            endcase
        end
        // quadrature state held still while the copy option is on
        if (!qRun) begin
            for (int k = 0; k < 3; k++) begin
                tap_d[k].q = tap_q[k].q;
            end
            odd_d.q = odd_q.q;
            out_d.q = out_q.q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tap_q <= '{default: '0};
            odd_q <= '0;
            out_q <= '0;
            st_q  <= hbc_pkg::HBC_IDLE;
            cnt_q <= 3'h0;
            ph_q  <= 3'h0;
            vld_q <= 1'b0;
        end else begin
            tap_q <= tap_d;
            odd_q <= odd_d;
            out_q <= out_d;
            st_q  <= st_d;
            cnt_q <= cnt_d;
            ph_q  <= ph_d;
            vld_q <= vld_d;
        end
    end

    assign outValid  = vld_q;
    assign outSample = out_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_pair;
        outValid ##GAP outValid;
    endsequence

    property p_double;
        !bypass && inValid && st_q == hbc_pkg::HBC_IDLE |=> s_pair;
    endproperty
    a_double: assert property (p_double) else $error("active stage did not emit two samples");

    property p_bypass_single;
        bypass && inValid |=> outValid && outSample.i == $past(inSample.i)
            && outSample.q == ($past(qRun) ? $past(inSample.q) : $past(outSample.q)) ##1 !outValid;
    endproperty
    a_bypass_single: assert property (p_bypass_single) else $error("bypass did not pass one sample");

    property p_qfreeze;
        !qRun && $past(!qRun) |-> $stable(outSample.q) && $stable(tap_q[0].q);
    endproperty
    a_qfreeze: assert property (p_qfreeze) else $error("quadrature state moved while gated");

endmodule
`default_nettype wire

// ==== hw/hbc_interp_mode_ctrl.sv ====
// interpolation chain mode registers, three cascaded stages and sideband/copy output
// Notes on behaviour
// - Sideband select clear gives the high-side image, set gives the spectrally inverted low-side image.
// - With the copy bit set, incoming quadrature samples are dropped and in-phase drives both outputs.
// - With the copy bit set, quadrature datapath state stops toggling.
// - First stage mode sits in bits 2:1; code 00 is the only unmodulated passband.
// - First stage codes 01, 10 and 11 modulate by one half, one and one and a half times the stage input rate.
// - First stage bypass routes samples around the filter with no rate doubling.
// - Second stage mode sits in bits 6:1 with eight unmodulated codes.
// - Second stage codes 100000 to 100111 modulate by the stage input rate.
// - Bit 0 of the second stage register bypasses that stage and resets to zero.
// - Third stage mode has eight unmodulated codes and resets to 000000.
// - Third stage codes 100000 to 100111 modulate by the stage input rate.
// - Bit 0 of the third stage register bypasses that stage and resets to zero.
`timescale 1ns/10ps
`default_nettype none
module hbc_interp_mode_ctrl (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic [7:0]           cfgAddr,
    input  wire logic [7:0]           cfgWrData,
    input  wire logic                 cfgWrEn,
    output logic [7:0]                cfgRdData,
    input  wire logic                 inValid,
    input  wire hbc_pkg::hbc_sample_t inSample,
    output logic                      outValid,
    output hbc_pkg::hbc_sample_t      outSample,
    output logic                      qPathActive
);
    hbc_pkg::hbc_cfg_t    cfg_q;
    hbc_pkg::hbc_cfg_t    cfg_d;
    logic [7:0]           rd_q;
    logic [7:0]           rd_d;
    hbc_pkg::hbc_sample_t out_q;
    hbc_pkg::hbc_sample_t out_d;
    logic                 vld_q;
    logic                 vld_d;
    logic                 qAct_q;
    logic                 qAct_d;

    logic                 qRun;
    hbc_pkg::hbc_sample_t s1In;
    logic                 s1Valid;
    hbc_pkg::hbc_sample_t s1Out;
    logic                 s2Valid;
    hbc_pkg::hbc_sample_t s2Out;
    logic                 s3Valid;
    hbc_pkg::hbc_sample_t s3Out;
    logic [2:0]           s1Step;
    logic [2:0]           s2Step;
    logic [2:0]           s3Step;

    // register file: written by the serial port's internal strobe, read back registered
    always_comb begin
        cfg_d = cfg_q;
        rd_d  = 8'h00;
        if (cfgWrEn) begin
            unique case (cfgAddr)
                hbc_pkg::HBC_ADDR_DP: begin
                    cfg_d.lowSideband       = cfgWrData[hbc_pkg::HBC_SIDEBAND_BIT];
                    cfg_d.inphaseCopyToQuad = cfgWrData[hbc_pkg::HBC_COPY_BIT];
                end
                hbc_pkg::HBC_ADDR_S1: begin
                    cfg_d.firstHalfbandMode = cfgWrData[hbc_pkg::HBC_S1_MODE_MSB:hbc_pkg::HBC_MODE_LSB];
                    cfg_d.firstStageBypass  = cfgWrData[hbc_pkg::HBC_BYPASS_BIT];
                end
                hbc_pkg::HBC_ADDR_S2: begin
                    cfg_d.secondHalfbandMode = cfgWrData[hbc_pkg::HBC_S6_MODE_MSB:hbc_pkg::HBC_MODE_LSB];
                    cfg_d.secondStageBypass  = cfgWrData[hbc_pkg::HBC_BYPASS_BIT];
                end
                hbc_pkg::HBC_ADDR_S3: begin
                    cfg_d.thirdHalfbandMode = cfgWrData[hbc_pkg::HBC_S6_MODE_MSB:hbc_pkg::HBC_MODE_LSB];
                    cfg_d.thirdStageBypass  = cfgWrData[hbc_pkg::HBC_BYPASS_BIT];
                end
                default: begin
                end
            endcase
        end
        unique case (cfgAddr)
            hbc_pkg::HBC_ADDR_DP: begin
                rd_d[hbc_pkg::HBC_SIDEBAND_BIT] = cfg_q.lowSideband;
                rd_d[hbc_pkg::HBC_COPY_BIT]     = cfg_q.inphaseCopyToQuad;
            end
            hbc_pkg::HBC_ADDR_S1: begin
                rd_d[hbc_pkg::HBC_S1_MODE_MSB:hbc_pkg::HBC_MODE_LSB] = cfg_q.firstHalfbandMode;
                rd_d[hbc_pkg::HBC_BYPASS_BIT]                        = cfg_q.firstStageBypass;
            end
            hbc_pkg::HBC_ADDR_S2: begin
                rd_d[hbc_pkg::HBC_S6_MODE_MSB:hbc_pkg::HBC_MODE_LSB] = cfg_q.secondHalfbandMode;
                rd_d[hbc_pkg::HBC_BYPASS_BIT]                        = cfg_q.secondStageBypass;
            end
            hbc_pkg::HBC_ADDR_S3: begin
                rd_d[hbc_pkg::HBC_S6_MODE_MSB:hbc_pkg::HBC_MODE_LSB] = cfg_q.thirdHalfbandMode;
                rd_d[hbc_pkg::HBC_BYPASS_BIT]                        = cfg_q.thirdStageBypass;
            end
            default: begin
                rd_d = 8'h00;
            end
        endcase
    end

    // copy option: drop incoming q and freeze the quadrature state downstream
    assign qRun   = !cfg_q.inphaseCopyToQuad;
    assign s1Step = hbc_pkg::hbc_step1(cfg_q.firstHalfbandMode);
    assign s2Step = hbc_pkg::hbc_step6(cfg_q.secondHalfbandMode);
    assign s3Step = hbc_pkg::hbc_step6(cfg_q.thirdHalfbandMode);

    always_comb begin
        s1In = inSample;
        if (cfg_q.inphaseCopyToQuad) begin
            s1In.q = '0;
        end
    end

    // fixed output gaps halve down the chain, so stage three can emit every cycle
    hbc_halfband_stage #(
        .GAP (hbc_pkg::HBC_GAP_S1)
    ) u_stage1 (
        .mclk      (mclk),
        .resetn    (resetn),
        .bypass    (cfg_q.firstStageBypass),
        .step      (s1Step),
        .qRun      (qRun),
        .inValid   (inValid),
        .inSample  (s1In),
        .outValid  (s1Valid),
        .outSample (s1Out)
    );

    hbc_halfband_stage #(
        .GAP (hbc_pkg::HBC_GAP_S2)
    ) u_stage2 (
        .mclk      (mclk),
        .resetn    (resetn),
        .bypass    (cfg_q.secondStageBypass),
        .step      (s2Step),
        .qRun      (qRun),
        .inValid   (s1Valid),
        .inSample  (s1Out),
        .outValid  (s2Valid),
        .outSample (s2Out)
    );

    hbc_halfband_stage #(
        .GAP (hbc_pkg::HBC_GAP_S3)
    ) u_stage3 (
        .mclk      (mclk),
        .resetn    (resetn),
        .bypass    (cfg_q.thirdStageBypass),
        .step      (s3Step),
        .qRun      (qRun),
        .inValid   (s2Valid),
        .inSample  (s2Out),
        .outValid  (s3Valid),
        .outSample (s3Out)
    );

    // output modulator: conjugation mirrors the spectrum to the low side
    always_comb begin
        out_d  = out_q;
        vld_d  = s3Valid;
        qAct_d = qRun;
        if (s3Valid) begin
            out_d = s3Out;
            if (cfg_q.lowSideband) begin
                out_d.q = hbc_pkg::hbc_neg(s3Out.q);
            end
            if (cfg_q.inphaseCopyToQuad) begin
                out_d.q = s3Out.i;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cfg_q  <= hbc_pkg::HBC_CFG_RST;
            rd_q   <= hbc_pkg::HBC_RD_RST;
            out_q  <= '0;
            vld_q  <= 1'b0;
            qAct_q <= 1'b1;
        end else begin
            cfg_q  <= cfg_d;
            rd_q   <= rd_d;
            out_q  <= out_d;
            vld_q  <= vld_d;
            qAct_q <= qAct_d;
        end
    end

    assign cfgRdData   = rd_q;
    assign outValid    = vld_q;
    assign outSample   = out_q;
    assign qPathActive = qAct_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_low_side;
        s3Valid && cfg_q.lowSideband && !cfg_q.inphaseCopyToQuad |=>
            outValid && outSample.q == hbc_pkg::hbc_neg($past(s3Out.q)) && outSample.i == $past(s3Out.i);
    endproperty
    a_low_side: assert property (p_low_side) else $error("low-side image not inverted");

    property p_high_side;
        s3Valid && !cfg_q.lowSideband && !cfg_q.inphaseCopyToQuad |=> outSample == $past(s3Out);
    endproperty
    a_high_side: assert property (p_high_side) else $error("high-side image altered");

    property p_copy;
        s3Valid && cfg_q.inphaseCopyToQuad |=> outValid && outSample.q == outSample.i;
    endproperty
    a_copy: assert property (p_copy) else $error("in-phase not copied to quadrature");

    property p_s2_write;
        cfgWrEn && cfgAddr == hbc_pkg::HBC_ADDR_S2 |=>
            cfg_q.secondHalfbandMode == $past(cfgWrData[6:1]) && cfg_q.secondStageBypass == $past(cfgWrData[0]);
    endproperty
    a_s2_write: assert property (p_s2_write) else $error("second stage register not written");

    property p_reset_value;
        $rose(resetn) |-> cfg_q == hbc_pkg::HBC_CFG_RST && !outValid && qPathActive;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad value after reset");

    sequence s_s1_addr;
        cfgAddr == hbc_pkg::HBC_ADDR_S1 && !cfgWrEn;
    endsequence

    property p_s1_read;
        s_s1_addr |=> cfgRdData == {5'h00, $past(cfg_q.firstHalfbandMode), $past(cfg_q.firstStageBypass)};
    endproperty
    a_s1_read: assert property (p_s1_read) else $error("first stage readback wrong");

endmodule
`default_nettype wire

// ==== tb/hbc_stream_partner.sv ====
// upstream sample source and downstream output capture
`timescale 1ns/10ps
`default_nettype none
module hbc_stream_partner (
    input  wire logic                 mclk,
    input  wire logic                 outValid,
    input  wire hbc_pkg::hbc_sample_t outSample,
    output logic                      inValid,
    output hbc_pkg::hbc_sample_t      inSample
);
    hbc_pkg::hbc_sample_t seen[$];
    initial begin
        inValid = 1'b0;
        inSample = '0;
    end
    // eight cycles apart, the full-rate spacing with every stage active
    task automatic send(input int n, input hbc_pkg::hbc_sample_t v);
        repeat (n) begin
            @(negedge mclk);
            inValid = 1'b1;
            inSample = v;
            @(negedge mclk);
            inValid = 1'b0;
            // released data shows no stale copy
            inSample = ~v;
            repeat (6) @(negedge mclk);
        end
    endtask
    always @(negedge mclk) begin
        if (outValid === 1'b1)
            seen.push_back(outSample);
    end
endmodule
`default_nettype wire

// ==== tb/hbc_interp_mode_ctrl_tb.sv ====
// self-checking bench for the interpolation mode control block
`timescale 1ns/10ps
`default_nettype none
module hbc_interp_mode_ctrl_tb;
    logic                 mclk      = 1'b0;
    logic                 resetn    = 1'b0;
    logic [7:0]           cfgAddr   = 8'h00;
    logic [7:0]           cfgWrData = 8'h00;
    logic                 cfgWrEn   = 1'b0;
    logic [7:0]           cfgRdData;
    logic                 inValid;
    logic                 outValid;
    logic                 qPathActive;
    hbc_pkg::hbc_sample_t inSample;
    hbc_pkg::hbc_sample_t outSample;
    hbc_pkg::hbc_sample_t v;
    int                   nMismatch = 0;
    int                   numChecks = 0;
    localparam logic [7:0] ADR [4] = '{8'h1b, 8'h1c, 8'h1d, 8'h1e};
    localparam logic [7:0] MSK [4] = '{8'h03, 8'h07, 8'h7f, 8'h7f};
    localparam logic [7:0] MA [12] = '{8'h1c, 8'h1c, 8'h1c, 8'h1c, 8'h1d, 8'h1d,
                                       8'h1d, 8'h1d, 8'h1e, 8'h1e, 8'h1e, 8'h1e};
    localparam logic [7:0] MD [12] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h00, 8'h24,
                                       8'h48, 8'h6c, 8'h00, 8'h24, 8'h48, 8'h4a};
    // quarter turns per output; last entry is a reserved code
    localparam int         MK [12] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 1, 2, 2};

    always #20 mclk = ~mclk;

    hbc_interp_mode_ctrl uut (
        .mclk(mclk), .resetn(resetn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
        .cfgWrEn(cfgWrEn), .cfgRdData(cfgRdData), .inValid(inValid), .inSample(inSample),
        .outValid(outValid), .outSample(outSample), .qPathActive(qPathActive)
    );
    hbc_stream_partner src (
        .mclk(mclk), .outValid(outValid), .outSample(outSample),
        .inValid(inValid), .inSample(inSample)
    );

    task automatic close_out;
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
        numChecks++;
        if (got !== x) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, x, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        cfgAddr = a;
        cfgWrData = d;
        cfgWrEn = 1'b1;
        @(negedge mclk);
        cfgWrEn = 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
        @(negedge mclk);
        cfgAddr = a;
        @(negedge mclk);
        chk("cfgRdData", 32'(x), 32'(cfgRdData));
    endtask

    function automatic hbc_pkg::hbc_sample_t rotk(input hbc_pkg::hbc_sample_t s, input int k);
        case (k)
            1: return {-s.q, s.i};
            2: return {-s.i, -s.q};
            3: return {s.q, -s.i};
            default: return s;
        endcase
    endfunction

    task automatic run(input int n, input int outs);
        src.seen.delete();
        src.send(n, v);
        repeat (40) @(negedge mclk);
        chk("output count", 32'(outs), 32'(src.seen.size()));
    endtask

    task automatic flat(input hbc_pkg::hbc_sample_t x);
        foreach (src.seen[j])
            chk("outSample", x, src.seen[j]);
    endtask

    // settled tail turns by k quarters per output and keeps the input magnitude
    task automatic steady(input int k);
        int n;
        logic hit;
        n = src.seen.size();
        hit = 1'b0;
        if (n >= 4) begin
            for (int j = n - 4; j < n - 1; j++)
                chk("rotation", rotk(src.seen[j], k), src.seen[j + 1]);
            for (int m = 0; m < 4; m++)
                hit = hit | (src.seen[n - 1] === rotk(v, m));
        end
        chk("magnitude", 32'h1, 32'(hit));
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        nMismatch++;
        close_out();
    end

    initial begin
        v = {16'sh0400, 16'sh0200};
        repeat (6) @(negedge mclk);
        resetn = 1'b1;
        for (int i = 0; i < 4; i++)
            rdchk(ADR[i], 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(ADR[i], 8'hff);
            rdchk(ADR[i], MSK[i]);
        end
        wr(8'h20, 8'hff);
        rdchk(8'h20, 8'h00);
        $display("test registers done");
        // all bypassed with modes set, copy and sideband both on
        run(3, 3);
        flat({v.i, v.i});
        chk("qPathActive", 32'h0, 32'(qPathActive));
        wr(8'h1b, 8'h02);
        run(3, 3);
        flat({v.i, -v.q});
        chk("qPathActive", 32'h1, 32'(qPathActive));
        wr(8'h1b, 8'h00);
        run(3, 3);
        flat(v);
        $display("test bypass done");
        for (int i = 0; i < 12; i++) begin
            wr(8'h1c, 8'h01);
            wr(8'h1d, 8'h01);
            wr(8'h1e, 8'h01);
            wr(MA[i], MD[i]);
            run(8, 16);
            steady(MK[i]);
        end
        $display("test modes done");
        // reset between runs must bring every field back to its value after reset
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        for (int i = 0; i < 4; i++)
            rdchk(ADR[i], 8'h00);
        chk("qPathActive", 32'h1, 32'(qPathActive));
        $display("test reset done");
        wr(8'h1c, 8'h00);
        wr(8'h1d, 8'h00);
        wr(8'h1e, 8'h00);
        run(8, 64);
        steady(0);
        $display("test cascade done");
        close_out();
    end
endmodule
`default_nettype wire
